// ### inc/ahps_pkg.sv
// constants, register map and types for the axis homing pulse sequencer
// assumes one 100 MHz clock and a 32-bit AHB-Lite register port
package ahps_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int RAMP_UNIT_NS  = 1_000_000;
	localparam int CYC_PER_MS    = RAMP_UNIT_NS / CLK_PERIOD_NS;
	localparam int CLK_HZ        = 1_000_000_000 / CLK_PERIOD_NS;
	localparam logic [31:0] PEAK_MAX_HZ = 32'h0003_0D40;
	// byte offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_START  = 8'h04;
	localparam logic [7:0] OFS_PEAK   = 8'h08;
	localparam logic [7:0] OFS_RAMP   = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_POS0   = 8'h14;
	localparam logic [7:0] OFS_POS1   = 8'h18;
	localparam logic [7:0] OFS_IRQ_ST = 8'h1C;
	localparam logic [7:0] OFS_IRQ_MK = 8'h20;
	// control word fields
	localparam int CB_ENABLE  = 0;
	localparam int CB_TRIGGER = 1;
	localparam int CB_MODE    = 2;
	localparam int CB_DIR     = 3;
	localparam int CB_AXIS    = 4;
	localparam int CB_STOP    = 5;
	localparam int CB_ESTOP_C = 6;
	localparam int CB_DIRDIS0 = 8;
	localparam int CB_DIRDIS1 = 9;
	localparam int CB_CLR0    = 10;
	localparam int CB_CLR1    = 11;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	// status fields; done and fault also sit at bits 0 and 1 of the interrupt registers
	localparam int SB_DONE  = 0;
	localparam int SB_FAULT = 1;
	localparam int SB_BUSY  = 2;
	localparam int SB_ESTOP = 3;
	localparam int SB_CODE  = 8;
	// fault codes
	localparam logic [7:0] FC_NONE       = 8'h00;
	localparam logic [7:0] FC_RAMP_SHORT = 8'h01;
	localparam logic [7:0] FC_PEAK_HIGH  = 8'h02;
	localparam logic [7:0] FC_START_LOW  = 8'h03;
	localparam logic [7:0] FC_RAMP_PULSE = 8'h04;
	localparam logic [7:0] FC_START_PEAK = 8'h05;
	typedef enum logic [2:0] {ST_IDLE, ST_ACCEL, ST_CRUISE, ST_DECEL, ST_CREEP} ahps_state_t;
endpackage : ahps_pkg

// ### inc/ahps_pulse_if.sv
// link between the sequencer and its pulse-train generator
// both ends sit on the same clock
interface ahps_pulse_if;
	logic        run;
	logic [31:0] freq;
	logic        pulse;
	logic        step;
	modport gen (input run, input freq, output pulse, output step);
	modport seq (output run, output freq, input pulse, input step);
endinterface : ahps_pulse_if

// ### hw/ahps_pulse_gen.sv
// phase-accumulator pulse-train generator, square wave at freq hertz
// assumes freq below half the clock rate; run low parks the output low
module ahps_pulse_gen
	import ahps_pkg::*;
(
	// clock and reset
	input  wire logic mclk,
	input  wire logic reset_n,
	// sequencer side
	ahps_pulse_if.gen pif
);
	localparam logic [32:0] HALF_WRAP = 33'(CLK_HZ);
	logic [27:0] acc_reg;
	logic [32:0] sum;

	// adding twice the rate gives two toggles, one whole pulse, per period
	assign sum = {5'h00, acc_reg} + {pif.freq, 1'b0};

	always_ff @(posedge mclk) begin
		if (!reset_n || !pif.run) begin
			acc_reg   <= 28'h0000000;
			pif.pulse <= 1'b0;
			pif.step  <= 1'b0;
		end else if (sum >= HALF_WRAP) begin
			acc_reg   <= 28'(sum - HALF_WRAP);
			pif.pulse <= ~pif.pulse;
			// count a pulse on its falling edge, once it is complete
			pif.step  <= pif.pulse;
		end else begin
			acc_reg  <= sum[27:0];
			pif.step <= 1'b0;
		end
	end
endmodule : ahps_pulse_gen

// ### hw/ahps_sequencer.sv
// homing sequencer for two pulse axes with an AHB-Lite register slave
// assumes hready is this slave's own hreadyout; sensors are asynchronous pins
//
// Overview of operation
// - with enable set, a trigger rising edge starts the homing move
// - axis select 0 drives pulse channel zero, 1 drives channel one
// - mode 0: decelerate when near-origin goes high, stop on origin
// - mode 1: stop as soon as the origin input goes high
// - count rises per pulse for direction 0, falls for direction 1
// - ramp time in ms sets equal acceleration and deceleration times
// - reaching origin leaves the position count unchanged
// - position counts clear only through their count-clear bits
// - done reads 1 after successful homing, 0 until then
// - fault flag reads 1 after an error; byte fault code names it
// - starts only while enable is 1 and never alters that enable
// - direction output 0 forward, 1 backward, unless direction disabled
// - count-clear bit 1 clears the count, 0 keeps it
// - while emergency-stop is set nothing starts; software clears it
// - fault codes 0 none,1 short ramp,2 peak high,3 start low,4 never set,5 start>peak
module ahps_sequencer
	import ahps_pkg::*;
#(
	parameter int RAMP_CYC_PER_MS = CYC_PER_MS
) (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        reset_n,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	// sensors
	input  wire logic        origin_in,
	input  wire logic        near_origin_in,
	// drive side
	output logic             pulse_out_ch0,
	output logic             pulse_out_ch1,
	output logic             dir_out_ch0,
	output logic             dir_out_ch1,
	output logic             irq
);
	ahps_pulse_if pif ();
	ahps_pulse_gen u_gen (.mclk(mclk), .reset_n(reset_n), .pif(pif));

	ahps_state_t state_reg;
	logic [31:0] ctrl_reg, peak_reg, peak_lat_reg, diff_reg, cur_freq_reg;
	logic [15:0] start_reg, ramp_reg;
	logic [47:0] racc_reg, ramp_cyc_reg, ramp_cyc, racc_sum;
	logic [31:0] pos0_reg, pos1_reg, hrdata_reg, rdata_next;
	logic [7:0]  fault_code_reg, wr_ofs_reg, fault_next;
	logic [2:0]  irq_st_reg, irq_mk_reg, irq_set;
	logic [1:0]  origin_sync_reg, near_sync_reg;
	logic        wr_pend_reg, trig_d_reg, done_reg, err_reg, estop_reg;
	logic        axis_reg, mode_reg, dir_reg, pulse0_reg, pulse1_reg;
	logic        dir0_reg, dir1_reg, irq_reg, addr_ok, rd_irq_st, go, tick;
	logic        origin_s, near_s, running, stop_cmd;

	// AHB slave: zero wait states, always OKAY
	assign addr_ok   = hsel && htrans[1] && hready;
	assign rd_irq_st = addr_ok && !hwrite && haddr[7:0] == OFS_IRQ_ST;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_reg;

	always_comb begin
		unique case (haddr[7:0])
			OFS_CTRL:   rdata_next = ctrl_reg;
			OFS_START:  rdata_next = {16'h0000, start_reg};
			OFS_PEAK:   rdata_next = peak_reg;
			OFS_RAMP:   rdata_next = {16'h0000, ramp_reg};
			OFS_STATUS: rdata_next = {16'h0000, fault_code_reg, 4'h0, estop_reg, running, err_reg, done_reg};
			OFS_POS0:   rdata_next = pos0_reg;
			OFS_POS1:   rdata_next = pos1_reg;
			OFS_IRQ_ST: rdata_next = {29'h00000000, irq_st_reg};
			OFS_IRQ_MK: rdata_next = {29'h00000000, irq_mk_reg};
			default:    rdata_next = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			wr_pend_reg <= 1'b0;
			wr_ofs_reg  <= 8'h00;
			hrdata_reg  <= 32'h0000_0000;
		end else begin
			wr_pend_reg <= addr_ok && hwrite;
			wr_ofs_reg  <= haddr[7:0];
			if (addr_ok && !hwrite)
				hrdata_reg <= rdata_next;
		end
	end

	// stop and estop-clear are write strobes and never stay set
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			ctrl_reg  <= CTRL_RESET;
			start_reg <= 16'h0000;
			peak_reg  <= 32'h0000_0000;
			ramp_reg  <= 16'h0000;
			irq_mk_reg <= 3'h0;
		end else begin
			ctrl_reg[CB_STOP]    <= 1'b0;
			ctrl_reg[CB_ESTOP_C] <= 1'b0;
			if (wr_pend_reg) begin
				unique case (wr_ofs_reg)
					OFS_CTRL:   ctrl_reg   <= hwdata;
					OFS_START:  start_reg  <= hwdata[15:0];
					OFS_PEAK:   peak_reg   <= hwdata;
					OFS_RAMP:   ramp_reg   <= hwdata[15:0];
					OFS_IRQ_MK: irq_mk_reg <= hwdata[2:0];
					// counts and status are read-only here
					default:    ;
				endcase
			end
		end
	end

	// sensor synchronisers
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			origin_sync_reg <= 2'b00;
			near_sync_reg   <= 2'b00;
		end else begin
			origin_sync_reg <= {origin_sync_reg[0], origin_in};
			near_sync_reg   <= {near_sync_reg[0], near_origin_in};
		end
	end
	assign origin_s = origin_sync_reg[1];
	assign near_s   = near_sync_reg[1];

	assign running  = state_reg != ST_IDLE;
	assign stop_cmd = ctrl_reg[CB_STOP];
	// enable is only read, so execution leaves it alone
	assign go = ctrl_reg[CB_TRIGGER] && !trig_d_reg && ctrl_reg[CB_ENABLE]
		&& !estop_reg && !running;
	assign ramp_cyc = 48'(ramp_reg) * 48'(RAMP_CYC_PER_MS);
	assign racc_sum = racc_reg + {16'h0000, diff_reg};
	assign tick     = racc_sum >= ramp_cyc_reg;

	// validation order: peak range, start floor, start vs peak, ramp slope
	always_comb begin
		if (peak_reg > PEAK_MAX_HZ)
			fault_next = FC_PEAK_HIGH;
		else if (start_reg == 16'h0000)
			fault_next = FC_START_LOW;
		else if ({16'h0000, start_reg} > peak_reg)
			fault_next = FC_START_PEAK;
		else if (ramp_cyc < {16'h0000, peak_reg - {16'h0000, start_reg}})
			fault_next = FC_RAMP_SHORT;
		else
			fault_next = FC_NONE;
	end

	// at most one frequency step per clock, guaranteed by the slope check
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			state_reg      <= ST_IDLE;
			trig_d_reg     <= 1'b0;
			cur_freq_reg   <= 32'h0000_0000;
			racc_reg       <= 48'h0;
			ramp_cyc_reg   <= 48'h0;
			diff_reg       <= 32'h0000_0000;
			peak_lat_reg   <= 32'h0000_0000;
			axis_reg       <= 1'b0;
			mode_reg       <= 1'b0;
			dir_reg        <= 1'b0;
			done_reg       <= 1'b0;
			err_reg        <= 1'b0;
			fault_code_reg <= FC_NONE;
		end else begin
			trig_d_reg <= ctrl_reg[CB_TRIGGER];
			if (go) begin
				done_reg       <= 1'b0;
				fault_code_reg <= fault_next;
				err_reg        <= fault_next != FC_NONE;
				axis_reg       <= ctrl_reg[CB_AXIS];
				mode_reg       <= ctrl_reg[CB_MODE];
				dir_reg        <= ctrl_reg[CB_DIR];
				cur_freq_reg   <= {16'h0000, start_reg};
				peak_lat_reg   <= peak_reg;
				diff_reg       <= peak_reg - {16'h0000, start_reg};
				ramp_cyc_reg   <= ramp_cyc;
				racc_reg       <= 48'h0;
				if (fault_next == FC_NONE)
					state_reg <= ST_ACCEL;
			end else if (running) begin
				racc_reg <= tick ? racc_sum - ramp_cyc_reg : racc_sum;
				if (stop_cmd) begin
					state_reg <= ST_IDLE;
				end else if (origin_s) begin
					state_reg <= ST_IDLE;
					done_reg  <= 1'b1;
				end else if (!mode_reg && near_s && (state_reg == ST_ACCEL || state_reg == ST_CRUISE)) begin
					state_reg <= ST_DECEL;
					racc_reg  <= 48'h0;
				end else begin
					unique case (state_reg)
						ST_ACCEL: begin
							if (cur_freq_reg >= peak_lat_reg)
								state_reg <= ST_CRUISE;
							else if (tick)
								cur_freq_reg <= cur_freq_reg + 32'h1;
						end
						ST_DECEL: begin
							if (cur_freq_reg <= peak_lat_reg - diff_reg)
								state_reg <= ST_CREEP;
							else if (tick)
								cur_freq_reg <= cur_freq_reg - 32'h1;
						end
						default: ;
					endcase
				end
			end
		end
	end
	assign pif.run  = running;
	assign pif.freq = cur_freq_reg;

	// emergency stop: set by the stop bit, which wins over the estop-clear bit
	always_ff @(posedge mclk) begin
		if (!reset_n)
			estop_reg <= 1'b0;
		else if (stop_cmd)
			estop_reg <= 1'b1;
		else if (ctrl_reg[CB_ESTOP_C])
			estop_reg <= 1'b0;
	end

	// position counts; origin does not touch them
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			pos0_reg <= 32'h0000_0000;
			pos1_reg <= 32'h0000_0000;
		end else begin
			if (ctrl_reg[CB_CLR0])
				pos0_reg <= 32'h0000_0000;
			else if (pif.step && !axis_reg)
				pos0_reg <= dir_reg ? pos0_reg - 32'h1 : pos0_reg + 32'h1;
			if (ctrl_reg[CB_CLR1])
				pos1_reg <= 32'h0000_0000;
			else if (pif.step && axis_reg)
				pos1_reg <= dir_reg ? pos1_reg - 32'h1 : pos1_reg + 32'h1;
		end
	end

	// pin drivers; a disabled direction channel is held low
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			pulse0_reg <= 1'b0;
			pulse1_reg <= 1'b0;
			dir0_reg   <= 1'b0;
			dir1_reg   <= 1'b0;
		end else begin
			pulse0_reg <= pif.pulse && !axis_reg;
			pulse1_reg <= pif.pulse && axis_reg;
			dir0_reg   <= !ctrl_reg[CB_DIRDIS0] && (running && !axis_reg ? dir_reg : ctrl_reg[CB_DIR]);
			dir1_reg   <= !ctrl_reg[CB_DIRDIS1] && (running && axis_reg ? dir_reg : ctrl_reg[CB_DIR]);
		end
	end
	assign pulse_out_ch0 = pulse0_reg;
	assign pulse_out_ch1 = pulse1_reg;
	assign dir_out_ch0   = dir0_reg;
	assign dir_out_ch1   = dir1_reg;

	// interrupt: done, fault, emergency stop; reading clears, new events win
	assign irq_set = {stop_cmd, go && fault_next != FC_NONE, running && origin_s && !stop_cmd};
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			irq_st_reg <= 3'h0;
			irq_reg    <= 1'b0;
		end else begin
			irq_st_reg <= (rd_irq_st ? 3'h0 : irq_st_reg) | irq_set;
			irq_reg    <= |(irq_st_reg & irq_mk_reg);
		end
	end
	assign irq = irq_reg;

	a_start_edge: assert property (@(posedge mclk) disable iff (!reset_n)
		go |=> running || err_reg) else $error("trigger edge did not start homing");
	a_near_decel: assert property (@(posedge mclk) disable iff (!reset_n)
		(!mode_reg && near_s && !origin_s && !stop_cmd && (state_reg == ST_ACCEL || state_reg == ST_CRUISE))
		|=> state_reg == ST_DECEL) else $error("no deceleration on near origin");
	a_origin_stop: assert property (@(posedge mclk) disable iff (!reset_n)
		(running && origin_s && !stop_cmd) |=> !running && done_reg) else $error("origin did not stop");
	a_count_fwd: assert property (@(posedge mclk) disable iff (!reset_n)
		(pif.step && !axis_reg && !dir_reg && !ctrl_reg[CB_CLR0]) |=> pos0_reg == $past(pos0_reg) + 32'h1)
		else $error("forward count did not rise");
	a_ramp_bound: assert property (@(posedge mclk) disable iff (!reset_n)
		running |-> cur_freq_reg <= peak_lat_reg) else $error("frequency above peak");
	a_count_clear: assert property (@(posedge mclk) disable iff (!reset_n)
		ctrl_reg[CB_CLR1] |=> pos1_reg == 32'h0000_0000) else $error("count clear ignored");
	a_fault_code: assert property (@(posedge mclk) disable iff (!reset_n)
		(go && fault_next != FC_NONE) |=> err_reg && !running && fault_code_reg != FC_NONE)
		else $error("faulted start ran or lost its code");
	a_done_idle: assert property (@(posedge mclk) disable iff (!reset_n)
		done_reg |-> !running) else $error("done while moving");
	a_estop_block: assert property (@(posedge mclk) disable iff (!reset_n)
		(estop_reg && !running) |=> !running) else $error("start under emergency stop");
	a_dir_disable: assert property (@(posedge mclk) disable iff (!reset_n)
		ctrl_reg[CB_DIRDIS0] |=> !dir_out_ch0) else $error("disabled direction driven");
	a_idle_pulse: assert property (@(posedge mclk) disable iff (!reset_n)
		$fell(running) |-> ##2 !pulse_out_ch0 && !pulse_out_ch1) else $error("pulse not idle after stop");
endmodule : ahps_sequencer

// ### sim/ahps_drive_model.sv
// drive and sensor model: tallies finished pulses on both channels
// assumes pulses idle low; sensors read 0 until the bench arms a move
module ahps_drive_model (
	// clock
	input  wire logic        mclk,
	// bench control
	input  wire logic        arm,
	input  wire logic [7:0]  near_at,
	// pulse trains from the sequencer
	input  wire logic        pulse_out_ch0,
	input  wire logic        pulse_out_ch1,
	// sensors and tallies
	output logic             near_origin_in,
	output logic             origin_in,
	output logic [31:0]      cnt0,
	output logic [31:0]      cnt1
);
	timeunit 1ns;
	timeprecision 1ps;
	// origin lands early in a low half-period so a forced stop never ends a pulse
	localparam int GAP = 200;
	logic p0_q;
	logic p1_q;
	int   gap_cnt;
	// outputs settle at the first edge, while the bench still holds arm low
	always @(posedge mclk) begin
		p0_q <= pulse_out_ch0;
		p1_q <= pulse_out_ch1;
		if (!arm) begin
			cnt0 <= '0;
			cnt1 <= '0;
			near_origin_in <= 1'b0;
			origin_in <= 1'b0;
			gap_cnt <= 0;
		end else begin
			if (p0_q && !pulse_out_ch0)
				cnt0 <= cnt0 + 32'h1;
			if (p1_q && !pulse_out_ch1)
				cnt1 <= cnt1 + 32'h1;
			if (cnt0 + cnt1 >= {24'h0, near_at})
				near_origin_in <= 1'b1;
			if (near_origin_in)
				gap_cnt <= gap_cnt + 1;
			if (gap_cnt == GAP)
				origin_in <= 1'b1;
		end
	end
endmodule : ahps_drive_model

// ### sim/test_axis_homing_pulse_sequencer.sv
// self-checking bench for the homing sequencer over its AHB-Lite port
// assumes the drive model for sensors; one 100 MHz clock
module test_axis_homing_pulse_sequencer
	import ahps_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk, reset_n, hsel, hwrite, hreadyout, hresp, irq, arm;
	logic        origin_in, near_origin_in, pulse_out_ch0, pulse_out_ch1, dir_out_ch0, dir_out_ch1;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata, c0, c1, d;
	int          n_mismatch = 0;
	int          compares = 0;
	int          i;
	logic [31:0] f_start[4] = '{32'h64, 32'h0, 32'h7D, 32'h64};
	logic [31:0] f_peak[4]  = '{32'h30D41, 32'h9C40, 32'h7C, 32'h9C40};
	logic [31:0] f_ramp[4]  = '{32'hF96, 32'hF96, 32'hF96, 32'hF95};
	logic [7:0]  f_code[4]  = '{FC_PEAK_HIGH, FC_START_LOW, FC_START_PEAK, FC_RAMP_SHORT};
	// short ms so ramps fit the run
	ahps_sequencer #(.RAMP_CYC_PER_MS(10)) uut (.mclk(mclk), .reset_n(reset_n), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.origin_in(origin_in), .near_origin_in(near_origin_in), .pulse_out_ch0(pulse_out_ch0),
		.pulse_out_ch1(pulse_out_ch1), .dir_out_ch0(dir_out_ch0), .dir_out_ch1(dir_out_ch1), .irq(irq));
	ahps_drive_model drv (.mclk(mclk), .arm(arm), .near_at(8'h02), .pulse_out_ch0(pulse_out_ch0),
		.pulse_out_ch1(pulse_out_ch1), .near_origin_in(near_origin_in), .origin_in(origin_in),
		.cnt0(c0), .cnt1(c1));
	task automatic results;
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : results
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic ahb_xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge mclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge mclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : ahb_xfer
	task automatic ahb_wr(input logic [7:0] a, input logic [31:0] wd);
		logic [31:0] x;
		ahb_xfer(1'b1, a, wd, x);
	endtask : ahb_wr
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] x;
		ahb_xfer(1'b0, a, 32'h0, x);
		chk(x, exp);
	endtask : rchk
	task automatic home(input logic m, input logic dr, input logic ax);
		logic [31:0] base, st, e;
		logic        pl;
		base = {27'h0, ax, dr, m, 2'b01};
		arm <= 1'b0;
		ahb_wr(OFS_CTRL, base | 32'hC00);
		ahb_wr(OFS_CTRL, base);
		arm <= 1'b1;
		ahb_wr(OFS_CTRL, base | 32'h2);
		rchk(OFS_STATUS, 32'h4);
		st = 32'h4;
		// poll bound stays inside the watchdog span
		for (int k = 0; k < 12000 && st[SB_BUSY] !== 1'b0; k++)
			ahb_xfer(1'b0, OFS_STATUS, 32'h0, st);
		chk(st, 32'h1);
		rchk(OFS_IRQ_ST, 32'h1);
		e = ax ? c1 : c0;
		if (dr)
			e = -e;
		rchk(ax ? OFS_POS1 : OFS_POS0, e);
		chk(ax ? c0 : c1, 32'h0);
		chk({31'h0, ax ? dir_out_ch1 : dir_out_ch0}, {31'h0, dr});
		pl = 1'b0;
		repeat (300) begin
			@(posedge mclk);
			pl = pl | pulse_out_ch0 | pulse_out_ch1;
		end
		chk({31'h0, pl}, 32'h0);
		ahb_wr(ax ? OFS_POS1 : OFS_POS0, 32'h0);
		rchk(ax ? OFS_POS1 : OFS_POS0, e);
		rchk(OFS_CTRL, base | 32'h2);
		ahb_wr(OFS_CTRL, base | (ax ? 32'h800 : 32'h400));
		rchk(ax ? OFS_POS1 : OFS_POS0, 32'h0);
		ahb_wr(OFS_CTRL, base);
		$display("test homing mode %0d axis %0d done", m, ax);
	endtask : home
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// the tests need about half this span
	initial begin
		repeat (90000) @(posedge mclk);
		n_mismatch++;
		results();
	end
	initial begin
		{reset_n, hsel, hwrite, htrans, haddr, hwdata, arm} = '0;
		repeat (3) @(posedge mclk);
		reset_n <= 1'b1;
		rchk(OFS_CTRL, CTRL_RESET);
		chk({31'h0, hresp}, 32'h0);
		rchk(8'h40, 32'h0);
		ahb_wr(OFS_CTRL, 32'h2);
		rchk(OFS_STATUS, 32'h0);
		ahb_wr(OFS_CTRL, 32'h8);
		repeat (2) @(posedge mclk);
		chk({31'h0, dir_out_ch0}, 32'h1);
		ahb_wr(OFS_CTRL, 32'h108);
		repeat (2) @(posedge mclk);
		chk({31'h0, dir_out_ch0}, 32'h0);
		$display("test idle controls done");
		ahb_wr(OFS_START, 32'h64);
		ahb_wr(OFS_PEAK, 32'h9C40);
		ahb_wr(OFS_RAMP, 32'hF96);
		home(1'b0, 1'b0, 1'b0);
		home(1'b1, 1'b1, 1'b1);
		arm <= 1'b0;
		for (i = 0; i < 4; i++) begin
			ahb_xfer(1'b0, OFS_IRQ_ST, 32'h0, d);
			ahb_wr(OFS_IRQ_MK, i == 0 ? 32'h2 : 32'h0);
			ahb_wr(OFS_START, f_start[i]);
			ahb_wr(OFS_PEAK, f_peak[i]);
			ahb_wr(OFS_RAMP, f_ramp[i]);
			ahb_wr(OFS_CTRL, 32'h1);
			ahb_wr(OFS_CTRL, 32'h3);
			rchk(OFS_STATUS, {16'h0, f_code[i], 8'h02});
			chk({31'h0, irq}, {31'h0, i == 0});
			rchk(OFS_IRQ_ST, 32'h2);
			repeat (2) @(posedge mclk);
			chk({31'h0, irq}, 32'h0);
		end
		$display("test fault codes done");
		ahb_wr(OFS_START, 32'h64);
		ahb_wr(OFS_PEAK, PEAK_MAX_HZ);
		ahb_wr(OFS_RAMP, 32'h4E16);
		ahb_wr(OFS_CTRL, 32'h1);
		ahb_wr(OFS_CTRL, 32'h3);
		rchk(OFS_STATUS, 32'h4);
		ahb_wr(OFS_CTRL, 32'h23);
		rchk(OFS_STATUS, 32'h8);
		rchk(OFS_IRQ_ST, 32'h4);
		ahb_wr(OFS_CTRL, 32'h1);
		ahb_wr(OFS_CTRL, 32'h3);
		rchk(OFS_STATUS, 32'h8);
		ahb_wr(OFS_CTRL, 32'h41);
		rchk(OFS_STATUS, 32'h0);
		$display("test emergency stop done");
		results();
	end
endmodule : test_axis_homing_pulse_sequencer
